// ===== fspr_pkg.sv
// constants for the flash status and array protection block
// Behaviour
// - Lock bit S8 at 1 blocks all status writes until power is cycled.
// - The lock is either volatile until power-up or permanent through OTP.
// - Suspend flag S15 sets on 75h, clears on 7Ah or power cycle.
// - Three security lock bits S13..S11 default to 0, unlocked.
// - Each security lock bit sets on its own and never clears again.
// - Read-only bit S16 shows current address width, 1 is four bytes.
// - Power-up width bit S17 is used only at init, written only via 06h.
// - Power-up width 0 starts in three-byte mode, 1 in four-byte mode.
// - Scheme bit S18 picks range protection at 0, block locks at 1.
// - All individual block locks are set at power-on and reset.
// - Drive bits S22,S21 give 100,75,50,25 percent; 25 percent default.
// - Reserved bits ignore writes; they read as zero here.
// - Range bits protect none, 2^(n-1) blocks from top/bottom, or all.
// - Complement bit inverts the protected region chosen by range bits.
// - Status writes need write enable; the latch clears when write ends.
// - Erase or program touching any protected block is ignored.
`default_nettype none

package fspr_pkg;
    // ==========================================================
    // instruction codes
    localparam logic [7:0] CMD_WREN = 8'h06;
    localparam logic [7:0] CMD_VWREN = 8'h50;
    localparam logic [7:0] CMD_WRDI = 8'h04;
    localparam logic [7:0] CMD_WRSR1 = 8'h01;
    localparam logic [7:0] CMD_WRSR2 = 8'h31;
    localparam logic [7:0] CMD_WRSR3 = 8'h11;
    localparam logic [7:0] CMD_RDSR1 = 8'h05;
    localparam logic [7:0] CMD_RDSR2 = 8'h35;
    localparam logic [7:0] CMD_RDSR3 = 8'h15;
    localparam logic [7:0] CMD_SUSPEND = 8'h75;
    localparam logic [7:0] CMD_RESUME = 8'h7a;
    localparam logic [7:0] CMD_EN4B = 8'hb7;
    localparam logic [7:0] CMD_EX4B = 8'he9;

    // ==========================================================
    // field positions within each status byte
    localparam int SR1_WEL = 1;
    localparam int SR1_BP_LO = 2;
    localparam int SR1_TB = 6;
    localparam int SR2_LOCK = 0;
    localparam int SR2_LB_LO = 3;
    localparam int SR2_CMP = 6;
    localparam int SR2_SUS = 7;
    localparam int SR3_ADS = 0;
    localparam int SR3_ADP = 1;
    localparam int SR3_WPS = 2;
    localparam int SR3_DRV_LO = 5;

    // ==========================================================
    // reset and factory values, plus last bit index, all-protect threshold and block number width
    localparam logic [1:0] DRV_DEFAULT = 2'h3;
    localparam logic [3:0] BP_DEFAULT = 4'h0;
    localparam logic [2:0] LB_DEFAULT = 3'h0;
    localparam logic ADP_DEFAULT = 1'b0;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BP_ALL_FROM = 4'ha;
    localparam int BLK_W = 9;
endpackage

`default_nettype wire

// ===== fspr_range_dec.sv
// range decode: does a block span hit the protected area
`timescale 1ns/1ps
`default_nettype none

module fspr_range_dec
    import fspr_pkg::*;
#(
    parameter int BW = BLK_W
) (
    // protection settings
    input wire logic cmp_in,
    input wire logic tb_in,
    input wire logic [3:0] bp_in,
    // target span, first and last block
    input wire logic [BW-1:0] first_in,
    input wire logic [BW-1:0] last_in,
    // result
    output logic hit_out
);
    logic none_w;
    logic [BW:0] cnt_w;
    logic [BW-1:0] lo_w;
    logic [BW-1:0] hi_w;
    logic inside_w;

    // protected interval before complement
    always_comb begin
        none_w = (bp_in == 4'h0);
        cnt_w = (BW+1)'(1) << (bp_in - 4'h1);
        lo_w = '0;
        hi_w = '1;
        if (bp_in < BP_ALL_FROM && !none_w) begin
            if (tb_in) begin
                hi_w = BW'(cnt_w - (BW+1)'(1));
            end else begin
                lo_w = BW'((BW+1)'(1) << BW) - BW'(cnt_w);
            end
        end
        inside_w = (first_in >= lo_w) && (last_in <= hi_w);
        // complement: the interval becomes the writable part
        if (cmp_in) begin
            hit_out = none_w ? 1'b1 : !inside_w;
        end else begin
            hit_out = none_w ? 1'b0 : (last_in >= lo_w && first_in <= hi_w);
        end
    end
endmodule // fspr_range_dec

`default_nettype wire

// ===== fspr_status_protect.sv
// status register control and array protection of one flash die
`timescale 1ns/1ps
`default_nettype none

module fspr_status_protect
    import fspr_pkg::*;
#(
    parameter int BW = BLK_W
) (
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire logic nv_factory_init_in,
    // serial pins
    input wire logic spi_cs_n_in,
    input wire logic spi_sclk_in,
    input wire logic spi_di_in,
    output logic spi_do_out,
    output logic spi_do_oe_n_out,
    // erase/program check from the array controller
    input wire logic pe_req_in,
    input wire logic [BW-1:0] pe_first_blk_in,
    input wire logic [BW-1:0] pe_last_blk_in,
    output logic pe_accept_out,
    output logic pe_ignore_out,
    // status seen by the rest of the die
    output logic status_write_lock_out,
    output logic suspend_flag_out,
    output logic [2:0] secure_region_lock_out,
    output logic current_addr_width_out,
    output logic protect_scheme_select_out,
    output logic [1:0] drive_strength_out,
    output logic blk_locks_all_set_out
);
    typedef struct packed {
        logic cs_s1, cs_s2, cs_d;
        logic ck_s1, ck_s2, ck_d;
        logic di_s1, di_s2;
        logic [3:0] bit_cnt;
        logic [7:0] shift_in;
        logic [7:0] opcode;
        logic have_op, have_data;
        logic [7:0] wdata;
        logic [7:0] shift_out;
        logic rd_active, miso, miso_oe_n;
        logic write_enable_latch, vwe;
        logic suspend, srl_vol, lock;
        logic cmp, tb;
        logic [3:0] bp;
        logic protect_scheme_select;
        logic [1:0] drv;
        logic current_addr_width, init_pend, blk_lock_all;
        logic pe_accept, pe_ignore;
        // kept across reset, like non-volatile cells
        logic srl_otp;
        logic [2:0] lb;
        logic powerup_addr_width;
    } fspr_state_s;

    fspr_state_s st_ff;
    fspr_state_s nxt_st;
    fspr_state_s rst_val;
    logic rise_w, fall_w, cs_start_w, cs_end_w;
    logic [7:0] byte_w;
    logic [7:0] rd_val_w;
    logic range_hit_w;
    logic pe_hit_w;
    logic wr_ok_w, nv_wr_w, is_wrsr_w;

    // ==========================================================
    // range decode of the span the array controller asks about
    fspr_range_dec #(
        .BW(BW)
    ) u_range (
        .cmp_in(st_ff.cmp),
        .tb_in(st_ff.tb),
        .bp_in(st_ff.bp),
        .first_in(pe_first_blk_in),
        .last_in(pe_last_blk_in),
        .hit_out(range_hit_w)
    );

    // scheme select picks range bits or the block locks
    assign pe_hit_w = st_ff.protect_scheme_select ? st_ff.blk_lock_all : range_hit_w;

    // ==========================================================
    // read value of the status byte named by an opcode
    always_comb begin
        rd_val_w = 8'h00; // reserved bits read as zero
        unique case (byte_w)
            CMD_RDSR1: begin
                rd_val_w[SR1_WEL] = st_ff.write_enable_latch;
                rd_val_w[SR1_BP_LO +: 4] = st_ff.bp;
                rd_val_w[SR1_TB] = st_ff.tb;
            end
            CMD_RDSR2: begin
                rd_val_w[SR2_LOCK] = st_ff.lock;
                rd_val_w[SR2_LB_LO +: 3] = st_ff.lb;
                rd_val_w[SR2_CMP] = st_ff.cmp;
                rd_val_w[SR2_SUS] = st_ff.suspend;
            end
            CMD_RDSR3: begin
                rd_val_w[SR3_ADS] = st_ff.current_addr_width;
                rd_val_w[SR3_ADP] = st_ff.powerup_addr_width;
                rd_val_w[SR3_WPS] = st_ff.protect_scheme_select;
                rd_val_w[SR3_DRV_LO +: 2] = st_ff.drv;
            end
            default: rd_val_w = 8'h00;
        endcase
    end

    // ==========================================================
    // edges of the sampled serial pins
    assign rise_w = st_ff.ck_s2 & ~st_ff.ck_d;
    assign fall_w = ~st_ff.ck_s2 & st_ff.ck_d;
    assign cs_start_w = ~st_ff.cs_s2 & st_ff.cs_d;
    assign cs_end_w = st_ff.cs_s2 & ~st_ff.cs_d;
    assign byte_w = {st_ff.shift_in[6:0], st_ff.di_s2};
    assign is_wrsr_w = (st_ff.opcode == CMD_WRSR1)
        || (st_ff.opcode == CMD_WRSR2) || (st_ff.opcode == CMD_WRSR3);
    // latch check; locked writes are dropped whole
    assign wr_ok_w = (st_ff.write_enable_latch | st_ff.vwe) & ~st_ff.lock;
    assign nv_wr_w = st_ff.write_enable_latch;

    // ==========================================================
    // next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.pe_accept = 1'b0;
        nxt_st.pe_ignore = 1'b0;
        // two-stage synchronisers, first stage read only by the second
        nxt_st.cs_s1 = spi_cs_n_in;
        nxt_st.cs_s2 = st_ff.cs_s1;
        nxt_st.cs_d = st_ff.cs_s2;
        nxt_st.ck_s1 = spi_sclk_in;
        nxt_st.ck_s2 = st_ff.ck_s1;
        nxt_st.ck_d = st_ff.ck_s2;
        nxt_st.di_s1 = spi_di_in;
        nxt_st.di_s2 = st_ff.di_s1;

        // width chosen from the power-up bit, once after reset
        if (st_ff.init_pend) begin
            nxt_st.current_addr_width = st_ff.powerup_addr_width;
            nxt_st.init_pend = 1'b0;
        end

        // shift in on rising edges, MSB first
        if (cs_start_w) begin
            nxt_st.bit_cnt = 4'h0;
            nxt_st.have_op = 1'b0;
            nxt_st.have_data = 1'b0;
            nxt_st.rd_active = 1'b0;
        end else if (!st_ff.cs_s2 && rise_w) begin
            nxt_st.shift_in = byte_w;
            nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
            if (st_ff.bit_cnt == BIT_LAST) begin
                nxt_st.bit_cnt = 4'h0;
                if (!st_ff.have_op) begin
                    nxt_st.opcode = byte_w;
                    nxt_st.have_op = 1'b1;
                    nxt_st.shift_out = rd_val_w;
                    nxt_st.rd_active = (byte_w == CMD_RDSR1)
                        || (byte_w == CMD_RDSR2) || (byte_w == CMD_RDSR3);
                end else if (!st_ff.have_data) begin
                    nxt_st.wdata = byte_w;
                    nxt_st.have_data = 1'b1;
                end
            end
        end

        // rotate out so clocking on repeats the same byte
        if (!st_ff.cs_s2 && fall_w && st_ff.rd_active) begin
            nxt_st.miso = st_ff.shift_out[7];
            nxt_st.shift_out = {st_ff.shift_out[6:0], st_ff.shift_out[7]};
        end
        if (cs_end_w) begin
            nxt_st.rd_active = 1'b0;
        end

        // commands act at deselect, only on whole bytes
        if (cs_end_w && st_ff.have_op && st_ff.bit_cnt == 4'h0) begin
            unique case (st_ff.opcode)
                CMD_WREN: begin
                    nxt_st.write_enable_latch = 1'b1;
                    nxt_st.vwe = 1'b0;
                end
                CMD_VWREN: nxt_st.vwe = 1'b1;
                CMD_WRDI: begin
                    nxt_st.write_enable_latch = 1'b0;
                    nxt_st.vwe = 1'b0;
                end
                CMD_SUSPEND: nxt_st.suspend = 1'b1;
                CMD_RESUME: nxt_st.suspend = 1'b0;
                CMD_EN4B: nxt_st.current_addr_width = 1'b1;
                CMD_EX4B: nxt_st.current_addr_width = 1'b0;
                CMD_WRSR1, CMD_WRSR2, CMD_WRSR3: begin
                    if (st_ff.have_data) begin
                        // latch drops whether or not the write lands
                        nxt_st.write_enable_latch = 1'b0;
                        nxt_st.vwe = 1'b0;
                    end
                end
                default: nxt_st.opcode = st_ff.opcode;
            endcase
            if (is_wrsr_w && st_ff.have_data && wr_ok_w) begin
                if (st_ff.opcode == CMD_WRSR1) begin
                    nxt_st.bp = st_ff.wdata[SR1_BP_LO +: 4];
                    nxt_st.tb = st_ff.wdata[SR1_TB];
                end else if (st_ff.opcode == CMD_WRSR2) begin
                    // 06h gives the permanent lock, 50h the volatile one
                    if (st_ff.wdata[SR2_LOCK]) begin
                        if (nv_wr_w) begin
                            nxt_st.srl_otp = 1'b1;
                        end else begin
                            nxt_st.srl_vol = 1'b1;
                        end
                    end
                    // security locks only ever gain ones
                    nxt_st.lb = st_ff.lb | st_ff.wdata[SR2_LB_LO +: 3];
                    nxt_st.cmp = st_ff.wdata[SR2_CMP];
                end else begin
                    if (nv_wr_w) begin
                        nxt_st.powerup_addr_width = st_ff.wdata[SR3_ADP];
                    end
                    nxt_st.protect_scheme_select = st_ff.wdata[SR3_WPS];
                    nxt_st.drv = st_ff.wdata[SR3_DRV_LO +: 2];
                end
            end
        end
        nxt_st.lock = nxt_st.srl_vol | nxt_st.srl_otp;
        nxt_st.miso_oe_n = ~(nxt_st.rd_active & ~st_ff.cs_s2);

        // span touching protection is dropped, not partly done
        if (pe_req_in) begin
            nxt_st.pe_ignore = pe_hit_w;
            nxt_st.pe_accept = ~pe_hit_w;
        end
    end

    // ==========================================================
    // power-up values; non-volatile cells survive unless factory init
    always_comb begin
        rst_val = '0;
        rst_val.cs_s1 = 1'b1;
        rst_val.cs_s2 = 1'b1;
        rst_val.cs_d = 1'b1;
        rst_val.miso_oe_n = 1'b1;
        rst_val.bp = BP_DEFAULT;
        rst_val.drv = DRV_DEFAULT;
        rst_val.init_pend = 1'b1;
        rst_val.blk_lock_all = 1'b1;
        rst_val.srl_otp = nv_factory_init_in ? 1'b0 : st_ff.srl_otp;
        rst_val.lb = nv_factory_init_in ? LB_DEFAULT : st_ff.lb;
        rst_val.powerup_addr_width = nv_factory_init_in ? ADP_DEFAULT : st_ff.powerup_addr_width;
        rst_val.lock = rst_val.srl_otp;
    end

    // ==========================================================
    // single state register; clock enable freezes everything
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st_ff <= rst_val;
        end else if (ce_in) begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register
    assign spi_do_out = st_ff.miso;
    assign spi_do_oe_n_out = st_ff.miso_oe_n;
    assign pe_accept_out = st_ff.pe_accept;
    assign pe_ignore_out = st_ff.pe_ignore;
    assign status_write_lock_out = st_ff.lock;
    assign suspend_flag_out = st_ff.suspend;
    assign secure_region_lock_out = st_ff.lb;
    assign current_addr_width_out = st_ff.current_addr_width;
    assign protect_scheme_select_out = st_ff.protect_scheme_select;
    assign drive_strength_out = st_ff.drv;
    assign blk_locks_all_set_out = st_ff.blk_lock_all;

    // ==========================================================
    // checks; one clock for all of them, quiet while reset is held
    default clocking ast_clk @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    AST_LOCK_FREEZE: assert property (
        st_ff.lock |=> $stable({st_ff.cmp, st_ff.bp, st_ff.tb, st_ff.protect_scheme_select,
            st_ff.drv, st_ff.lb, st_ff.powerup_addr_width}))
        else $error("status bits changed while locked");
    AST_OTP_KEEP: assert property (
        st_ff.srl_otp |=> st_ff.srl_otp && st_ff.lock)
        else $error("permanent lock fell");
    AST_SUS_CAUSE: assert property (
        $rose(st_ff.suspend) |-> $past(st_ff.opcode) == CMD_SUSPEND)
        else $error("suspend set without suspend command");
    AST_LB_STICKY: assert property (
        1'b1 |=> (st_ff.lb & $past(st_ff.lb)) == $past(st_ff.lb))
        else $error("security lock bit cleared");
    AST_ADS_INIT: assert property (
        (st_ff.init_pend && ce_in) |=> st_ff.current_addr_width == $past(st_ff.powerup_addr_width))
        else $error("address width not taken from power-up bit");
    AST_ADP_NV: assert property (
        $changed(st_ff.powerup_addr_width) |-> $past(st_ff.write_enable_latch) && !$past(st_ff.lock))
        else $error("power-up width changed without 06h write");
    AST_WEL_DROP: assert property (
        (ce_in && cs_end_w && st_ff.have_op && st_ff.have_data && is_wrsr_w
            && st_ff.bit_cnt == 4'h0) |=> !st_ff.write_enable_latch && !st_ff.vwe)
        else $error("write enable latch not cleared after write");
    AST_PE_IGNORE: assert property (
        (ce_in && pe_req_in && pe_hit_w) |=> pe_ignore_out && !pe_accept_out)
        else $error("protected span not ignored");
    AST_BLK_RESET: assert property (
        $past(reset_in) |-> blk_locks_all_set_out && drive_strength_out
            == DRV_DEFAULT)
        else $error("power-up lock or drive default wrong");
    AST_SCHEME: assert property (
        (ce_in && pe_req_in && st_ff.protect_scheme_select) |=> pe_ignore_out)
        else $error("block locks not applied under scheme select");
    AST_RANGE_NONE: assert property (
        (ce_in && pe_req_in && !st_ff.protect_scheme_select && !st_ff.cmp
            && st_ff.bp == 4'h0) |=> pe_accept_out)
        else $error("unprotected span refused");
    AST_CMP_ALL: assert property (
        (ce_in && pe_req_in && !st_ff.protect_scheme_select && st_ff.cmp
            && st_ff.bp == 4'h0) |=> pe_ignore_out)
        else $error("complement of none not fully protected");
endmodule // fspr_status_protect

`default_nettype wire

// ===== fspr_spi_host.sv
// serial host model that issues status instructions to one die
`timescale 1ns/1ps
`default_nettype none

module fspr_spi_host (
    // serial pins toward the die
    output logic cs_n_out,
    output logic sclk_out,
    output logic di_out,
    // reply from the die
    input wire logic do_in
);
    // ==========================================================
    // idle: deselected, clock parked low as mode 0 wants
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        di_out = 1'b0;
    end

    // ==========================================================
    // one byte out msb first while one byte comes back
    task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            di_out = tx[i];
            #62.5 sclk_out = 1'b1;
            rx[i] = do_in; // do settled well before this rise
            #62.5 sclk_out = 1'b0;
        end
    endtask

    // frame of an opcode and, if two is set, one further byte
    task automatic frame(input logic [7:0] op, input logic [7:0] dat,
        input bit two, output logic [7:0] rx);
        logic [7:0] junk;
        rx = 8'h00;
        cs_n_out = 1'b0;
        shift(op, junk);
        if (two) begin
            shift(dat, rx);
        end
        #62.5 cs_n_out = 1'b1;
        di_out = ~di_out; // released line must not look held
        #250; // gap well over four clocks, command has acted
    endtask
endmodule // fspr_spi_host

`default_nettype wire

// ===== fspr_status_protect_bench.sv
// testbench of the status register and array protection block
`timescale 1ns/1ps
`default_nettype none

module fspr_status_protect_bench;
    import fspr_pkg::*;

    typedef struct {
        logic [7:0] pre, wr, dat, rd, exp;
        logic [8:0] first, last;
        logic ign;
    } fspr_row_s;

    logic clk_in, reset_in, nv_init, cs_n, sclk, di, do_w, oe_n;
    logic ce, do_line;
    logic pe_req, pe_acc, pe_ign, lock, susp, width, protect_scheme_select, blks;
    logic [8:0] pe_first, pe_last;
    logic [2:0] lbs;
    logic [1:0] drv;
    int failures = 0;
    int n_compared = 0;

    // ==========================================================
    // table: enable or event, write, read back, block span check
    fspr_row_s rows [21] = '{
        '{8'h50, 8'h11, 8'h98, 8'h15, 8'h00, 0, 511, 0},
        '{8'h50, 8'h11, 8'h3c, 8'h15, 8'h24, 0, 0, 1},
        '{8'h50, 8'h11, 8'h40, 8'h15, 8'h40, 0, 0, 0},
        '{8'h50, 8'h11, 8'h60, 8'h15, 8'h60, 0, 0, 0},
        '{8'h50, 8'h01, 8'h04, 8'h05, 8'h04, 511, 511, 1},
        '{8'h00, 8'h00, 8'h00, 8'h05, 8'h04, 0, 510, 0},
        '{8'h50, 8'h01, 8'h64, 8'h05, 8'h64, 255, 256, 1},
        '{8'h00, 8'h00, 8'h00, 8'h05, 8'h64, 256, 511, 0},
        '{8'h50, 8'h01, 8'h30, 8'h05, 8'h30, 0, 0, 1},
        '{8'h50, 8'h01, 8'h28, 8'h05, 8'h28, 100, 100, 1},
        '{8'h50, 8'h01, 8'h04, 8'h05, 8'h04, 0, 0, 0},
        '{8'h50, 8'h31, 8'h40, 8'h35, 8'h40, 511, 511, 0},
        '{8'h00, 8'h00, 8'h00, 8'h35, 8'h40, 0, 510, 1},
        '{8'h50, 8'h31, 8'h00, 8'h35, 8'h00, 0, 0, 0},
        '{8'h06, 8'h31, 8'h08, 8'h35, 8'h08, 0, 0, 0},
        '{8'h06, 8'h31, 8'h10, 8'h35, 8'h18, 0, 0, 0},
        '{8'h06, 8'h31, 8'h00, 8'h35, 8'h18, 0, 0, 0},
        '{8'h75, 8'h00, 8'h00, 8'h35, 8'h98, 0, 0, 0},
        '{8'h7a, 8'h00, 8'h00, 8'h35, 8'h18, 0, 0, 0},
        '{8'h50, 8'h01, 8'h00, 8'h05, 8'h00, 0, 0, 0},
        '{8'h50, 8'h31, 8'h40, 8'h35, 8'h58, 0, 0, 1}};

    fspr_spi_host host (.cs_n_out(cs_n), .sclk_out(sclk), .di_out(di),
        .do_in(do_line));

    // undriven line shows the inverse, so a held last bit cannot pass
    assign do_line = oe_n ? ~do_w : do_w;

    fspr_status_protect dut (.clk_in(clk_in), .reset_in(reset_in),
        .ce_in(ce), .nv_factory_init_in(nv_init), .spi_cs_n_in(cs_n),
        .spi_sclk_in(sclk), .spi_di_in(di), .spi_do_out(do_w),
        .spi_do_oe_n_out(oe_n), .pe_req_in(pe_req),
        .pe_first_blk_in(pe_first), .pe_last_blk_in(pe_last),
        .pe_accept_out(pe_acc), .pe_ignore_out(pe_ign),
        .status_write_lock_out(lock), .suspend_flag_out(susp),
        .secure_region_lock_out(lbs), .current_addr_width_out(width),
        .protect_scheme_select_out(protect_scheme_select), .drive_strength_out(drv),
        .blk_locks_all_set_out(blks));

    // ==========================================================
    // 100 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic print_verdict;
        $display("compared %0d mismatched %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // optional enable or event frame, then optional write frame
    task automatic cmd(input logic [7:0] pre, input logic [7:0] op,
        input logic [7:0] dat);
        logic [7:0] junk;
        if (pre !== 8'h00) host.frame(pre, 8'h00, 1'b0, junk);
        if (op !== 8'h00) host.frame(op, dat, 1'b1, junk);
    endtask

    task automatic rd(input logic [7:0] op, input logic [7:0] e);
        logic [7:0] got;
        // mid data byte the die drives; after deselect it lets go
        fork
            host.frame(op, 8'h00, 1'b1, got);
            begin
                #1500;
                chk("read enable", 8'h00, {7'h0, oe_n});
            end
        join
        chk("status byte", e, got);
        chk("read enable idle", 8'h01, {7'h0, oe_n});
    endtask

    // one check request; the answer pulse stands the next cycle
    task automatic pe(input logic [8:0] f, input logic [8:0] l,
        input logic ign);
        @(posedge clk_in);
        #1 pe_req = 1'b1;
        pe_first = f;
        pe_last = l;
        @(posedge clk_in);
        #1 pe_req = 1'b0;
        chk("ignore pulse", {7'h0, ign}, {7'h0, pe_ign});
        chk("accept pulse", {7'h0, ~ign}, {7'h0, pe_acc});
    endtask

    // reset of eight cycles; fac returns non-volatile cells to 0
    task automatic pulse_reset(input logic fac);
        @(posedge clk_in);
        #1 reset_in = 1'b1;
        nv_init = fac;
        repeat (8) @(posedge clk_in);
        #1 reset_in = 1'b0;
        nv_init = 1'b0;
        repeat (10) @(posedge clk_in);
        #1;
    endtask

    // watchdog near three times the roughly 150 us of traffic
    initial begin
        #500000;
        failures++;
        print_verdict();
    end

    initial begin
        reset_in = 1'b1;
        ce = 1'b1;
        nv_init = 1'b1;
        pe_req = 1'b0;
        pe_first = 9'h000;
        pe_last = 9'h000;
        pulse_reset(1'b1);
        chk("drive", 8'h03, {6'h0, drv});
        chk("block locks", 8'h01, {7'h0, blks});
        chk("region locks", 8'h00, {5'h0, lbs});
        chk("scheme", 8'h00, {7'h0, protect_scheme_select});
        $display("test reset done");
        foreach (rows[i]) begin
            cmd(rows[i].pre, rows[i].wr, rows[i].dat);
            rd(rows[i].rd, rows[i].exp);
            if (rows[i].rd == 8'h15) begin
                chk("drive", {6'h0, rows[i].exp[6:5]}, {6'h0, drv});
                chk("scheme", {7'h0, rows[i].exp[2]}, {7'h0, protect_scheme_select});
            end
            pe(rows[i].first, rows[i].last, rows[i].ign);
        end
        // clock enable low: a check request leaves no pulse behind
        @(posedge clk_in);
        #1 ce = 1'b0;
        pe_req = 1'b1;
        @(posedge clk_in);
        #1 pe_req = 1'b0;
        chk("frozen pulses", 8'h00, {6'h0, pe_acc, pe_ign});
        ce = 1'b1;
        $display("test table done");
        // write with no enable first leaves the byte alone
        cmd(8'h00, 8'h11, 8'h00);
        rd(8'h15, 8'h60);
        // power-up width set, suspend pending, then reset
        cmd(8'h75, 8'h00, 8'h00);
        cmd(8'h06, 8'h11, 8'h62);
        rd(8'h15, 8'h62);
        pulse_reset(1'b0);
        chk("width", 8'h01, {7'h0, width});
        chk("suspend", 8'h00, {7'h0, susp});
        chk("drive", 8'h03, {6'h0, drv});
        chk("block locks", 8'h01, {7'h0, blks});
        rd(8'h15, 8'h63);
        rd(8'h35, 8'h18);
        cmd(8'h50, 8'h11, 8'h60);
        rd(8'h15, 8'h63);
        $display("test width done");
        // volatile lock blocks every status write until reset
        cmd(8'h50, 8'h31, 8'h01);
        chk("lock", 8'h01, {7'h0, lock});
        cmd(8'h06, 8'h11, 8'h00);
        rd(8'h15, 8'h63);
        rd(8'h35, 8'h19);
        pulse_reset(1'b0);
        chk("lock", 8'h00, {7'h0, lock});
        // permanent lock survives reset, factory init clears it
        cmd(8'h06, 8'h31, 8'h01);
        pulse_reset(1'b0);
        chk("lock", 8'h01, {7'h0, lock});
        pulse_reset(1'b1);
        chk("lock", 8'h00, {7'h0, lock});
        chk("width", 8'h00, {7'h0, width});
        rd(8'h35, 8'h00);
        $display("test lock done");
        print_verdict();
    end
endmodule // fspr_status_protect_bench

`default_nettype wire
